/* dcf_consts.svh */
// constants for the single clock block memory fifo
// assumes nothing beyond being included by its bare name
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_DW 9
`define DCF_AW 4
`define DCF_MODE_NORMAL 2'h0
`define DCF_MODE_THROUGH 2'h1
`define DCF_MODE_RBW 2'h2
`define DCF_PTR_RST 1'b0
`endif

/* dcf_fifo.sv */
// block memory with selectable port-a write behaviour and fifo control
// assumes all inputs synchronous to MCLK_IN; one clock serves push and pop side
//
// How it works
// - port a write behaviour is selectable as normal, write-through or read-before-write.
// - in normal behaviour port a output changes only on read cycles and clears, never on writes.
// - in write-through behaviour the pushed word appears on the port a output.
// - read-before-write shows the old word and only works at 9, 18 or 36 bit widths.
// - there is a push port with data, gate and strobe and a pop port with data, gate and strobe.
// - full, nearly full, nearly empty and empty are produced inside the block.
// - full and nearly full are registered on the push side.
// - empty and nearly empty are registered on the pop side.
// - the full threshold is programmable from 1 to two to the address width minus one.
// - nearly thresholds run from 1 to full minus one and empty is fixed at zero.
// - the port a clear empties the fifo, zeroes both pointers and resets the flags.
// - the port b rewind moves only the read pointer back so held data can be read again.
// - each port output latch clears asynchronously on its own port clear.
// - the chip-wide clear resets both output latches.
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dcf_fifo #(
  parameter int DW = `DCF_DW,
  parameter int AW = `DCF_AW
) (
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic CHIP_WIDE_CLEAR_N_IN,
  input wire logic PORT_A_FULL_CLEAR_IN,
  input wire logic PORT_B_POINTER_REWIND_IN,
  input wire dcf_pkg::dcf_wmode_t WRITE_MODE_IN,
  input wire logic [AW-1:0] FULL_THRESH_IN,
  input wire logic [AW-1:0] NEARLY_FULL_THRESH_IN,
  input wire logic [AW-1:0] NEARLY_EMPTY_THRESH_IN,
  input wire logic PUSH_SIDE_GATE_IN,
  input wire logic PUSH_STROBE_IN,
  input wire logic [DW-1:0] PUSH_DATA_IN,
  input wire logic [AW-1:0] PORT_A_ADDR_IN,
  output logic [DW-1:0] PORT_A_DATA_OUT,
  input wire logic POP_SIDE_GATE_IN,
  input wire logic OUTPUT_POP_STROBE_IN,
  output logic [DW-1:0] POP_DATA_OUT,
  output dcf_pkg::dcf_flags_t FLAGS_OUT
);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] wgray;
    logic [AW:0] rptr;
    logic [AW:0] rgray;
    logic [AW:0] rg_s1;
    logic [AW:0] rg_s2;
    logic [AW:0] wg_s1;
    logic [AW:0] wg_s2;
    dcf_pkg::dcf_flags_t flags;
  } dcf_state_t;

  localparam logic RBW_OK = (DW == 9) || (DW == 18) || (DW == 36);

  function automatic logic [AW:0] dcf_g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  dcf_state_t st;
  dcf_state_t next_st;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic push_ok;
  logic pop_ok;
  logic a_read;
  logic a_clr_n;
  logic b_clr_n;
  logic [AW:0] wcount;
  logic [AW:0] rcount;

  // a push or pop is only taken while its own registered flag allows it
  assign push_ok = PUSH_SIDE_GATE_IN & PUSH_STROBE_IN & ~st.flags.full & ~PORT_A_FULL_CLEAR_IN;
  assign pop_ok = POP_SIDE_GATE_IN & OUTPUT_POP_STROBE_IN & ~st.flags.empty
                  & ~PORT_A_FULL_CLEAR_IN & ~PORT_B_POINTER_REWIND_IN;
  assign a_read = PUSH_SIDE_GATE_IN & ~PUSH_STROBE_IN;
  assign a_clr_n = RESETN_IN & CHIP_WIDE_CLEAR_N_IN & ~PORT_A_FULL_CLEAR_IN;
  assign b_clr_n = RESETN_IN & CHIP_WIDE_CLEAR_N_IN & ~PORT_B_POINTER_REWIND_IN;

  always_comb begin
    next_st = st;
    // each side sees the other's gray pointer after two flops, except the write side on a rewind, which sees it at once
    next_st.rg_s1 = st.rgray;
    next_st.rg_s2 = st.rg_s1;
    next_st.wg_s1 = st.wgray;
    next_st.wg_s2 = st.wg_s1;
    if (push_ok) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (PORT_B_POINTER_REWIND_IN) begin
      // rewind to the start of the current lap so the count never passes depth
      next_st.rptr = {st.wptr[AW], {AW{1'b0}}};
    end else if (pop_ok) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    next_st.wgray = next_st.wptr ^ (next_st.wptr >> 1);
    next_st.rgray = next_st.rptr ^ (next_st.rptr >> 1);
    if (PORT_B_POINTER_REWIND_IN) begin
      // a rewind grows the count; a lagging copy would drop full and let a push overwrite held words
      next_st.rg_s1 = next_st.rgray;
      next_st.rg_s2 = next_st.rgray;
    end
    // flags are conservative: the far pointer lags by the sync delay
    wcount = next_st.wptr - dcf_g2b(PORT_B_POINTER_REWIND_IN ? next_st.rgray : st.rg_s2);
    rcount = dcf_g2b(st.wg_s2) - next_st.rptr;
    next_st.flags.full = wcount >= {1'b0, FULL_THRESH_IN};
    next_st.flags.nfull = wcount >= {1'b0, NEARLY_FULL_THRESH_IN};
    next_st.flags.empty = rcount == '0;
    next_st.flags.nempty = rcount <= {1'b0, NEARLY_EMPTY_THRESH_IN};
    if (PORT_A_FULL_CLEAR_IN) begin
      next_st = '0;
      next_st.flags.empty = 1'b1;
      next_st.flags.nempty = 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st <= '0;
      st.flags.empty <= 1'b1;
      st.flags.nempty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // storage has no reset; the clears act only on pointers, flags and output latches
  always_ff @(posedge MCLK_IN) begin
    if (push_ok) begin
      mem[st.wptr[AW-1:0]] <= PUSH_DATA_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge a_clr_n) begin
    if (!a_clr_n) begin
      PORT_A_DATA_OUT <= '0;
    end else if (push_ok) begin
      case (WRITE_MODE_IN)
        dcf_pkg::DCF_THROUGH: PORT_A_DATA_OUT <= PUSH_DATA_IN;
        dcf_pkg::DCF_RBW: begin
          // widths other than 9, 18 or 36 fall back to normal behaviour
          if (RBW_OK) begin
            PORT_A_DATA_OUT <= mem[st.wptr[AW-1:0]];
          end
        end
        default: PORT_A_DATA_OUT <= PORT_A_DATA_OUT;
      endcase
    end else if (a_read) begin
      PORT_A_DATA_OUT <= mem[PORT_A_ADDR_IN];
    end
  end

  always_ff @(posedge MCLK_IN or negedge b_clr_n) begin
    if (!b_clr_n) begin
      POP_DATA_OUT <= '0;
    end else if (pop_ok) begin
      POP_DATA_OUT <= mem[st.rptr[AW-1:0]];
    end
  end

  // packet tracking for replay lies with the user logic; the rewind alone is provided
  assign FLAGS_OUT = st.flags;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);

  full_blocks_push_a: assert property (
    (PUSH_SIDE_GATE_IN && PUSH_STROBE_IN && st.flags.full && !PORT_A_FULL_CLEAR_IN)
    |=> st.wptr == $past(st.wptr)) else $error("push taken while full");
  empty_blocks_pop_a: assert property (
    (OUTPUT_POP_STROBE_IN && st.flags.empty && !PORT_A_FULL_CLEAR_IN)
    |=> st.rptr == $past(st.rptr) || $past(PORT_B_POINTER_REWIND_IN))
    else $error("pop taken while empty");
  ignored_push_out_a: assert property (
    (PUSH_SIDE_GATE_IN && PUSH_STROBE_IN && st.flags.full && a_clr_n) ##1 a_clr_n
    |-> $stable(PORT_A_DATA_OUT)) else $error("ignored push changed port a output");
  ignored_pop_out_a: assert property (
    (POP_SIDE_GATE_IN && OUTPUT_POP_STROBE_IN && st.flags.empty && b_clr_n) ##1 b_clr_n
    |-> $stable(POP_DATA_OUT)) else $error("ignored pop changed pop output");
  push_step_a: assert property (push_ok |=> st.wptr == $past(st.wptr) + 1'b1)
    else $error("push did not advance write pointer");
  pop_step_a: assert property (pop_ok |=> st.rptr == $past(st.rptr) + 1'b1)
    else $error("pop did not advance read pointer");
  clear_empties_a: assert property (PORT_A_FULL_CLEAR_IN
    |=> st.wptr == '0 && st.rptr == '0 && FLAGS_OUT.empty && !FLAGS_OUT.full)
    else $error("port a clear did not empty fifo");
  rewind_keeps_wptr_a: assert property ((PORT_B_POINTER_REWIND_IN && !PORT_A_FULL_CLEAR_IN && !push_ok)
    |=> st.wptr == $past(st.wptr) && st.rptr[AW-1:0] == '0)
    else $error("rewind moved write pointer");
  through_output_a: assert property (
    (push_ok && a_clr_n && WRITE_MODE_IN == dcf_pkg::DCF_THROUGH) ##1 a_clr_n
    |-> PORT_A_DATA_OUT == $past(PUSH_DATA_IN)) else $error("write-through data missing");
  normal_holds_a: assert property (
    (push_ok && a_clr_n && WRITE_MODE_IN == dcf_pkg::DCF_NORMAL) ##1 a_clr_n
    |-> $stable(PORT_A_DATA_OUT)) else $error("normal write changed output");
  gray_step_a: assert property (
    ##1 $countones(st.wgray ^ $past(st.wgray)) <= 1 || $past(PORT_A_FULL_CLEAR_IN))
    else $error("write gray pointer moved more than one bit");

  // full and empty see the far pointer three edges late, so recent pops and pushes are allowed for
  full_needs_count_a: assert property (FLAGS_OUT.full
    |-> (st.wptr - st.rptr) >= {1'b0, FULL_THRESH_IN} || $changed(FULL_THRESH_IN)
    || $past(pop_ok) || $past(pop_ok, 2) || $past(pop_ok, 3)) else $error("full flag without enough words");
  empty_true_a: assert property (FLAGS_OUT.empty |-> st.wptr == st.rptr
    || $past(PORT_B_POINTER_REWIND_IN, 2) || $past(push_ok) || $past(push_ok, 2) || $past(push_ok, 3))
    else $error("empty flag while words held");
  // holds only for legal thresholds, nearly levels below full
  flag_nesting_a: assert property (
    (!FLAGS_OUT.full || FLAGS_OUT.nfull) && (!FLAGS_OUT.empty || FLAGS_OUT.nempty))
    else $error("nearly flags not nested inside full and empty");

  chip_clear_both_a: assert property (!CHIP_WIDE_CLEAR_N_IN
    |-> PORT_A_DATA_OUT == '0 && POP_DATA_OUT == '0) else $error("chip clear left an output latch set");
  clear_a_latch_a: assert property (PORT_A_FULL_CLEAR_IN
    |-> PORT_A_DATA_OUT == '0) else $error("port a clear left port a output set");
  rewind_b_latch_a: assert property (PORT_B_POINTER_REWIND_IN
    |-> POP_DATA_OUT == '0) else $error("port b rewind left pop output set");

  fill_up_c: cover property (push_ok ##1 FLAGS_OUT.full);
  nearly_full_c: cover property (FLAGS_OUT.nfull && !FLAGS_OUT.full);
  drain_c: cover property (pop_ok ##1 FLAGS_OUT.empty);
  rewind_c: cover property (pop_ok ##1 PORT_B_POINTER_REWIND_IN ##1 !FLAGS_OUT.empty);
  rbw_c: cover property (push_ok && WRITE_MODE_IN == dcf_pkg::DCF_RBW);
endmodule

/* dcf_pkg.sv */
// types shared by the fifo block
// assumes dcf_consts.svh is on the include path
`include "dcf_consts.svh"
package dcf_pkg;
  typedef enum logic [1:0] {
    DCF_NORMAL = `DCF_MODE_NORMAL,
    DCF_THROUGH = `DCF_MODE_THROUGH,
    DCF_RBW = `DCF_MODE_RBW
  } dcf_wmode_t;
  typedef struct packed {
    logic full;
    logic nfull;
    logic nempty;
    logic empty;
  } dcf_flags_t;
endpackage

/* dcf_user.sv */
// producer and consumer in fabric facing the fifo push and pop ports
// assumes requests from the bench change just after the rising edge
`timescale 1ns/1ns
module dcf_user (
  input wire logic clk_in,
  input wire logic push_req_in,
  input wire logic pop_req_in,
  input wire logic [8:0] data_in,
  output logic push_gate_out,
  output logic push_strobe_out,
  output logic pop_gate_out,
  output logic pop_strobe_out,
  output logic [8:0] push_data_out
);
  initial {push_gate_out, push_strobe_out, pop_gate_out, pop_strobe_out, push_data_out} = '0;
  // gate and strobe go together so a request is a single clean cycle
  always @(posedge clk_in) begin
    push_gate_out <= push_req_in;
    push_strobe_out <= push_req_in;
    pop_gate_out <= pop_req_in;
    pop_strobe_out <= pop_req_in;
    push_data_out <= push_req_in ? data_in : ~push_data_out;
  end
endmodule

/* testbench.sv */
// self-checking bench for the fifo against a queue model
// assumes dcf_user as the fabric partner; thresholds full 15, nearly full 12, nearly empty 3
`timescale 1ns/1ns
module testbench;
  logic MCLK_IN = 0, RESETN_IN = 0, clrn = 1, clr_a = 0, rew_b = 0, push_req = 0, pop_req = 0;
  logic pg, ps, rg, rs;
  logic [8:0] data = 9'h000, pdata, pa_out, pop_out, pa_exp = 9'h000, pop_exp = 9'h000, mem [16];
  dcf_pkg::dcf_wmode_t mode = dcf_pkg::DCF_THROUGH;
  dcf_pkg::dcf_flags_t flags;
  int n_mismatch = 0, checked = 0, wr = 0, rd = 0;
  dcf_user i_user(.clk_in(MCLK_IN), .push_req_in(push_req), .pop_req_in(pop_req), .data_in(data),
    .push_gate_out(pg), .push_strobe_out(ps), .pop_gate_out(rg), .pop_strobe_out(rs), .push_data_out(pdata));
  dcf_fifo i_dut(.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .CHIP_WIDE_CLEAR_N_IN(clrn),
    .PORT_A_FULL_CLEAR_IN(clr_a), .PORT_B_POINTER_REWIND_IN(rew_b), .WRITE_MODE_IN(mode),
    .FULL_THRESH_IN(4'hf), .NEARLY_FULL_THRESH_IN(4'hc), .NEARLY_EMPTY_THRESH_IN(4'h3),
    .PUSH_SIDE_GATE_IN(pg), .PUSH_STROBE_IN(ps), .PUSH_DATA_IN(pdata), .PORT_A_ADDR_IN(4'h0),
    .PORT_A_DATA_OUT(pa_out), .POP_SIDE_GATE_IN(rg), .OUTPUT_POP_STROBE_IN(rs),
    .POP_DATA_OUT(pop_out), .FLAGS_OUT(flags));
  initial forever #5 MCLK_IN = ~MCLK_IN;
  task automatic cmp_data(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flags(input int cnt);
    dcf_pkg::dcf_flags_t exp;
    exp = {cnt >= 15, cnt >= 12, cnt <= 3, cnt == 0};
    checked++;
    if (flags !== exp) begin
      n_mismatch++;
      $display("[FAIL] flags expected %b seen %b", exp, flags);
    end
  endtask
  task automatic settle();
    repeat (5) @(posedge MCLK_IN);
    #1 cmp_flags(wr - rd);
  endtask
  // one request per three cycles: partner register, then the taking edge
  task automatic push(input logic [8:0] d, input dcf_pkg::dcf_wmode_t m);
    @(posedge MCLK_IN);
    push_req <= 1'b1;
    data <= d;
    mode <= m;
    @(posedge MCLK_IN);
    push_req <= 1'b0;
    @(posedge MCLK_IN);
    #1;
    if (wr - rd < 15) begin
      pa_exp = (m == dcf_pkg::DCF_THROUGH) ? d : (m == dcf_pkg::DCF_RBW) ? mem[wr % 16] : pa_exp;
      mem[wr % 16] = d;
      wr++;
      cmp_data("port a", pa_exp, pa_out);
    end
  endtask
  task automatic pop();
    @(posedge MCLK_IN);
    pop_req <= 1'b1;
    @(posedge MCLK_IN);
    pop_req <= 1'b0;
    @(posedge MCLK_IN);
    #1;
    if (wr > rd) begin
      pop_exp = mem[rd % 16];
      rd++;
    end
    cmp_data("pop", pop_exp, pop_out);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #30000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'ha5b58bf7));
    repeat (12) @(posedge MCLK_IN);
    RESETN_IN <= 1'b1;
    settle();
    for (int i = 0; i < 16; i++) push(9'($urandom), dcf_pkg::DCF_THROUGH);
    settle();
    repeat (3) pop();
    settle();
    @(posedge MCLK_IN);
    rew_b <= 1'b1;
    @(posedge MCLK_IN);
    rew_b <= 1'b0;
    // replay restarts at the first word, the model keeps the packet boundary
    rd = 0;
    pop_exp = 9'h000;
    settle();
    cmp_data("pop after rewind", pop_exp, pop_out);
    repeat (16) pop();
    settle();
    repeat (2) push(9'($urandom), dcf_pkg::DCF_NORMAL);
    @(posedge MCLK_IN);
    clr_a <= 1'b1;
    @(posedge MCLK_IN);
    clr_a <= 1'b0;
    {wr, rd, pa_exp} = '0;
    settle();
    cmp_data("port a after clear", pa_exp, pa_out);
    push(9'($urandom), dcf_pkg::DCF_NORMAL);
    repeat (2) push(9'($urandom), dcf_pkg::DCF_RBW);
    settle();
    pop();
    @(posedge MCLK_IN);
    clrn <= 1'b0;
    #1 cmp_data("port a chip clear", 9'h000, pa_out);
    cmp_data("pop chip clear", 9'h000, pop_out);
    @(posedge MCLK_IN);
    clrn <= 1'b1;
    @(posedge MCLK_IN);
    give_verdict();
  end
endmodule
